// >>> design/i2c_register_slave.sv
// I2C slave-only target with a 256-byte register file behind an
// auto-incrementing 8-bit pointer.
// Assumes link_clk_i oversamples SCL well (12 ns period against 3.4 MHz
// SCL gives about 24 samples per bit) and srst_i is the supply power-on reset.
//
// What this block does
// - Decode only 7-bit address plus direction bit.
// - Leave SDA released for foreign addresses.
// - Main address picks one of two alternatives.
// - Byte registers selected by one-byte pointer.
// - Pointer steps by one per data byte.
// - Master clocks SCL; slave never drives SCL.
// - Works from static SCL up to 3.4 MHz.
// - One bit per SCL; SDA steady while high.
// - START is SDA fall, STOP SDA rise, SCL high.
// - Idle bus: both lines released high.
// - Eight bits MSB first, then acknowledge bit.
// - Repeated START restarts address reception.
// - After STOP or mismatch, ignore SCL until START.
// - Acknowledge: SDA low across ninth clock high.
// - Not-acknowledge: SDA released across ninth clock.
// - Acknowledge every pointer value, implemented or not.
// - Registers cleared only by supply power-on reset.
// - Address 0x48 strap high, 0x40 strap low.
// - Never acknowledge the general call address.
// - STOP leaves the register pointer unchanged.
`timescale 1ns/1ps

module i2c_register_slave
    import i2c_slave_pkg::*;
#(
    parameter int REG_COUNT = 256
) (
    // System clock and supply power-on reset.
    input wire logic clk_i,
    input wire logic srst_i,
    // Bus pins and the oversampling clock of the bus-facing logic.
    input wire logic link_clk_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    // Address-select strap.
    input wire logic addr_sel_i,
    // Register writes made by the bus master, system clock domain.
    output logic reg_wr_valid_o,
    output reg_wr_t reg_wr_o,
    // Register read port for the rest of the chip.
    input wire logic [7:0] sys_rd_addr_i,
    output logic [7:0] sys_rd_data_o
);

    // Synchronisers on the link clock: pins, strap and reset.
    logic scl_m, scl_s, scl_p, sda_m, sda_s, sda_p;
    logic sel_m, sel_s, lrst_m, lrst;
    // Bus-facing engine state.
    slave_state_t state, next_state;
    logic [3:0] bit_cnt, next_bit_cnt;
    logic [7:0] rx, next_rx, tx, next_tx, ptr, next_ptr;
    logic rw, next_rw, mack, next_mack, sda_oe, next_sda_oe;
    logic do_wr, do_rd;
    // Crossing words and toggles, link side.
    logic wr_tgl, rd_tgl;
    logic [7:0] wr_addr, wr_data, rd_addr, rd_buf;
    logic rack_m, rack_s, rack_p;
    // Crossing toggles and storage, system side.
    logic wr_m, wr_s, wr_p, rd_m, rd_s, rd_p, rd_ack_tgl;
    logic [7:0] rd_data_x;
    logic [7:0] regs [REG_COUNT];

    // Two flops on every asynchronous input before any logic reads it.
    always_ff @(posedge link_clk_i) begin
        scl_m <= scl_i;
        scl_s <= scl_m;
        scl_p <= scl_s;
        sda_m <= sda_i;
        sda_s <= sda_m;
        sda_p <= sda_s;
        sel_m <= addr_sel_i;
        sel_s <= sel_m;
        lrst_m <= srst_i;
        lrst <= lrst_m;
    end

    // Sampled lines decoded at any SCL rate.
    wire start_det = scl_s & scl_p & sda_p & ~sda_s;
    wire stop_det = scl_s & scl_p & ~sda_p & sda_s;
    wire scl_rise = scl_s & ~scl_p;
    wire scl_fall = ~scl_s & scl_p;

    wire [6:0] own_addr = sel_s ? `SLV_ADDR_SEL_HI : `SLV_ADDR_SEL_LO;
    wire gen_call = (rx[7:1] == `SLV_GEN_CALL);
    // Seven address bits, direction in bit 0.
    wire addr_hit = (rx[7:1] == own_addr) & ~gen_call;
    wire [7:0] ptr_plus = ptr + `PTR_STEP;
    wire unit_ack = (bit_cnt == `UNIT_ACK_SLOT);
    wire unit_done = (bit_cnt == `UNIT_DONE);

    // Engine next-state logic; START and STOP outrank clock edges.
    always_comb begin
        next_state = state;
        next_bit_cnt = bit_cnt;
        next_rx = rx;
        next_tx = tx;
        next_ptr = ptr;
        next_rw = rw;
        next_mack = mack;
        next_sda_oe = sda_oe;
        do_wr = 1'b0;
        do_rd = 1'b0;
        if (start_det) begin
            next_state = ST_ADDR;
            next_bit_cnt = `UNIT_FIRST;
            next_sda_oe = 1'b0;
        end else if (stop_det) begin
            next_state = ST_IDLE;
            next_bit_cnt = `UNIT_FIRST;
            next_sda_oe = 1'b0;
        end else if (state != ST_IDLE) begin
            if (scl_rise) begin
                if (bit_cnt < `UNIT_BITS) begin
                    next_rx = {rx[6:0], sda_s};
                    next_bit_cnt = bit_cnt + 4'h1;
                end else if (unit_ack) begin
                    // Master answer sampled on the ninth clock.
                    next_mack = ~sda_s;
                    next_bit_cnt = `UNIT_DONE;
                end
            end else if (scl_fall) begin
                if (unit_ack) begin
                    case (state)
                        ST_ADDR: begin
                            if (addr_hit) begin
                                next_sda_oe = 1'b1;
                                next_rw = rx[0];
                            end else begin
                                next_state = ST_IDLE;
                                next_sda_oe = 1'b0;
                            end
                        end
                        ST_PTR: begin
                            next_sda_oe = 1'b1;
                            next_ptr = rx;
                            do_rd = 1'b1;
                        end
                        ST_WDATA: begin
                            next_sda_oe = 1'b1;
                            do_wr = 1'b1;
                            next_ptr = ptr_plus;
                            do_rd = 1'b1;
                        end
                        ST_RDATA: begin
                            // Release so the master can answer.
                            next_sda_oe = 1'b0;
                        end
                        default: begin
                            next_sda_oe = 1'b0;
                        end
                    endcase
                end else if (unit_done) begin
                    next_bit_cnt = `UNIT_FIRST;
                    next_sda_oe = 1'b0;
                    case (state)
                        ST_ADDR: begin
                            if (rw) begin
                                next_state = ST_RDATA;
                                next_tx = {rd_buf[6:0], 1'b0};
                                next_sda_oe = ~rd_buf[7];
                                next_ptr = ptr_plus;
                                do_rd = 1'b1;
                            end else begin
                                next_state = ST_PTR;
                            end
                        end
                        ST_PTR: begin
                            next_state = ST_WDATA;
                        end
                        ST_WDATA: begin
                            next_state = ST_WDATA;
                        end
                        ST_RDATA: begin
                            if (mack) begin
                                next_tx = {rd_buf[6:0], 1'b0};
                                next_sda_oe = ~rd_buf[7];
                                next_ptr = ptr_plus;
                                do_rd = 1'b1;
                            end else begin
                                next_state = ST_IDLE;
                            end
                        end
                        default: begin
                            next_state = ST_IDLE;
                        end
                    endcase
                end else if (state == ST_RDATA) begin
                    // Next data bit placed while SCL is low.
                    next_sda_oe = ~tx[7];
                    next_tx = {tx[6:0], 1'b0};
                end
            end
        end
    end

    // Engine registers; the pointer is not cleared by STOP.
    always_ff @(posedge link_clk_i) begin
        if (lrst) begin
            state <= ST_IDLE;
            bit_cnt <= `UNIT_FIRST;
            rx <= `REG_RESET;
            tx <= `REG_RESET;
            ptr <= `PTR_RESET;
            rw <= 1'b0;
            mack <= 1'b0;
            sda_oe <= 1'b0;
        end else begin
            state <= next_state;
            bit_cnt <= next_bit_cnt;
            rx <= next_rx;
            tx <= next_tx;
            ptr <= next_ptr;
            rw <= next_rw;
            mack <= next_mack;
            sda_oe <= next_sda_oe;
        end
    end

    // Requests toward the register file; words are held until the next
    // request, which is at least nine SCL periods away.
    always_ff @(posedge link_clk_i) begin
        if (lrst) begin
            wr_tgl <= 1'b0;
            wr_addr <= `PTR_RESET;
            wr_data <= `REG_RESET;
            rd_tgl <= 1'b0;
            rd_addr <= `PTR_RESET;
        end else begin
            if (do_wr) begin
                wr_tgl <= ~wr_tgl;
                wr_addr <= ptr;
                wr_data <= rx;
            end
            if (do_rd) begin
                rd_tgl <= ~rd_tgl;
                rd_addr <= next_ptr;
            end
        end
    end

    // Prefetched read byte comes back by toggle; the word is only taken
    // once the toggle has crossed, so it is stable when sampled.
    always_ff @(posedge link_clk_i) begin
        rack_m <= rd_ack_tgl;
        rack_s <= rack_m;
        if (lrst) begin
            rack_p <= 1'b0;
            rd_buf <= `REG_RESET;
        end else begin
            rack_p <= rack_s;
            if (rack_s != rack_p) begin
                rd_buf <= rd_data_x;
            end
        end
    end

    // Only SDA is ever driven; SCL has no output at all.
    // Released whenever no acknowledge or zero bit is due.
    assign sda_o = 1'b0;
    assign sda_oe_o = sda_oe;

    // Toggle synchronisers on the system clock.
    always_ff @(posedge clk_i) begin
        wr_m <= wr_tgl;
        wr_s <= wr_m;
        rd_m <= rd_tgl;
        rd_s <= rd_m;
    end

    // A toggle that differs from its last copy marks one request.
    wire wr_evt = (wr_s != wr_p);
    wire rd_evt = (rd_s != rd_p);
    // Cells cleared only by the supply power-on reset.
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            for (int i = 0; i < REG_COUNT; i++) begin
                regs[i] <= `REG_RESET;
            end
        end else if (wr_evt) begin
            regs[wr_addr] <= wr_data;
        end
    end

    // Write notification, read answer and chip-side read port.
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            wr_p <= 1'b0;
            rd_p <= 1'b0;
            rd_ack_tgl <= 1'b0;
            rd_data_x <= `REG_RESET;
            reg_wr_valid_o <= 1'b0;
            reg_wr_o <= '0;
            sys_rd_data_o <= `REG_RESET;
        end else begin
            wr_p <= wr_s;
            rd_p <= rd_s;
            reg_wr_valid_o <= wr_evt;
            if (wr_evt) begin
                reg_wr_o <= '{addr: wr_addr, data: wr_data};
            end
            if (rd_evt) begin
                rd_data_x <= regs[rd_addr];
                rd_ack_tgl <= rd_s;
            end
            sys_rd_data_o <= regs[sys_rd_addr_i];
        end
    end

endmodule

// >>> design/i2c_slave_regs.svh
// Constants of the I2C register slave: addresses, counts and reset values.
// Assumes inclusion by bare name from the package; the design file uses its macros without including it.
`ifndef I2C_SLAVE_REGS_SVH
`define I2C_SLAVE_REGS_SVH

// Main 7-bit slave addresses picked by the address-select strap.
`define SLV_ADDR_SEL_HI 7'h48
`define SLV_ADDR_SEL_LO 7'h40
// General call address, never acknowledged.
`define SLV_GEN_CALL 7'h00
// Bit counter values within one nine-clock transfer unit.
`define UNIT_BITS 4'h8
`define UNIT_ACK_SLOT 4'h8
`define UNIT_DONE 4'h9
`define UNIT_FIRST 4'h0
// Reset values of the pointer and the register cells, and the pointer step.
`define PTR_RESET 8'h00
`define REG_RESET 8'h00
`define PTR_STEP 8'h01
// Fastest supported bus clock in kHz; the link clock must oversample it.
`define SCL_MAX_KHZ 3400

`endif

// >>> design/i2c_slave_pkg.sv
// Types shared by the I2C register slave.
// Assumes the constants header sits beside it in design/.
package i2c_slave_pkg;

    `include "i2c_slave_regs.svh"

    // Protocol phase of the bus-facing engine.
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_PTR,
        ST_WDATA,
        ST_RDATA
    } slave_state_t;

    // One register cell write, as seen by the rest of the chip.
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] data;
    } reg_wr_t;

endpackage

// >>> bench/i2c_register_slave_chk.sv
// Concurrent checks on the ports of the I2C register slave.
// Assumes the slave package is compiled first; bound at the file foot.
`timescale 1ns/1ps
module i2c_register_slave_chk
    import i2c_slave_pkg::*;
#(
    parameter int REG_COUNT = 256
) (
    // Clocks and reset.
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic link_clk_i,
    // Bus side.
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe_o,
    input wire logic addr_sel_i,
    // Chip side.
    input wire logic reg_wr_valid_o,
    input wire reg_wr_t reg_wr_o,
    input wire logic [7:0] sys_rd_addr_i,
    input wire logic [7:0] sys_rd_data_o
);
    logic [3:0] quiet_cnt;
    logic sda_prev;
    // Counts link samples with SCL high and SDA unchanged; saturates so it never wraps.
    always_ff @(posedge link_clk_i) begin
        sda_prev <= sda_i;
        if (srst_i || !scl_i || sda_i != sda_prev) quiet_cnt <= 4'h0;
        else if (quiet_cnt != 4'hf) quiet_cnt <= quiet_cnt + 4'h1;
    end
    property p_drive_low; @(posedge clk_i) disable iff (srst_i) sda_o == 1'b0; endproperty
    a_drive_low: assert property (p_drive_low) else $error("sda_o is not a pull-low value");
    property p_quiet_hold; @(posedge link_clk_i) disable iff (srst_i) quiet_cnt >= 4'h8 |-> $stable(sda_oe_o); endproperty
    a_quiet_hold: assert property (p_quiet_hold) else $error("SDA drive moved while SCL high");
    property p_rise_low; @(posedge link_clk_i) disable iff (srst_i) $rose(sda_oe_o) |-> !scl_i; endproperty
    a_rise_low: assert property (p_rise_low) else $error("SDA pulled low while SCL high");
    property p_rise_hold; @(posedge link_clk_i) disable iff (srst_i) $rose(sda_oe_o) |-> sda_oe_o [*8]; endproperty
    a_rise_hold: assert property (p_rise_hold) else $error("SDA pull too short");
    property p_fall_hold; @(posedge link_clk_i) disable iff (srst_i) $fell(sda_oe_o) |=> !sda_oe_o [*6]; endproperty
    a_fall_hold: assert property (p_fall_hold) else $error("SDA release too short");
    property p_start_idle; @(posedge link_clk_i) disable iff (srst_i) $fell(sda_i) && scl_i |-> !sda_oe_o [*8]; endproperty
    a_start_idle: assert property (p_start_idle) else $error("SDA driven during address");
    property p_stop_idle; @(posedge link_clk_i) disable iff (srst_i) $rose(sda_i) && scl_i |-> !sda_oe_o [*8]; endproperty
    a_stop_idle: assert property (p_stop_idle) else $error("SDA driven after stop");
    property p_wr_pulse; @(posedge clk_i) disable iff (srst_i) reg_wr_valid_o |=> !reg_wr_valid_o; endproperty
    a_wr_pulse: assert property (p_wr_pulse) else $error("write strobe longer than one cycle");
    property p_wr_hold; @(posedge clk_i) disable iff (srst_i) !reg_wr_valid_o |-> $stable(reg_wr_o); endproperty
    a_wr_hold: assert property (p_wr_hold) else $error("write record changed without strobe");
    property p_rd_port; @(posedge clk_i) disable iff (srst_i)
        $changed(sys_rd_data_o) |-> $past(reg_wr_valid_o) || ($past(sys_rd_addr_i) != $past(sys_rd_addr_i, 2));
    endproperty
    a_rd_port: assert property (p_rd_port) else $error("read port changed with no write or new address");
    // Main scenarios: acknowledge, register write, stop, register write with the strap high.
    c_ack: cover property (@(posedge link_clk_i) disable iff (srst_i) $rose(sda_oe_o));
    c_write: cover property (@(posedge clk_i) disable iff (srst_i) reg_wr_valid_o);
    c_stop: cover property (@(posedge link_clk_i) disable iff (srst_i) $rose(sda_i) && scl_i);
    c_strap: cover property (@(posedge clk_i) disable iff (srst_i) addr_sel_i && reg_wr_valid_o);
endmodule

bind i2c_register_slave i2c_register_slave_chk #(.REG_COUNT(REG_COUNT)) u_chk (.clk_i(clk_i), .srst_i(srst_i),
    .link_clk_i(link_clk_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
    .addr_sel_i(addr_sel_i), .reg_wr_valid_o(reg_wr_valid_o), .reg_wr_o(reg_wr_o),
    .sys_rd_addr_i(sys_rd_addr_i), .sys_rd_data_o(sys_rd_data_o));

// >>> bench/i2c_master_model.sv
// Behavioural I2C bus master driving SCL and an open-drain SDA.
// Assumes the bench resolves SDA with a pull-up and feeds the wire back.
`timescale 1ns/1ps
module i2c_master_model (
    // Bus wire as seen, and this master's own drive.
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_rel_o,
    // One strobe per byte taken from the slave.
    output logic rx_valid_o,
    output logic [7:0] rx_data_o
);
    int half_ns = 500;
    initial begin
        scl_o = 1'b1;
        sda_rel_o = 1'b1;
        rx_valid_o = 1'b0;
        rx_data_o = 8'h00;
    end
    // SDA moves only while SCL is low
    task automatic clk_bit(input logic b, output logic s);
        #(half_ns / 2);
        sda_rel_o = b;
        #(half_ns / 2);
        scl_o = 1'b1;
        #(half_ns / 2);
        s = sda_i;
        #(half_ns / 2);
        scl_o = 1'b0;
    endtask
    // start flips SDA low, stop flips it high, with SCL high
    task automatic cond(input logic start);
        #(half_ns / 2);
        sda_rel_o = start;
        #(half_ns / 2);
        scl_o = 1'b1;
        #(half_ns / 2);
        sda_rel_o = ~start;
        #(half_ns / 2);
        if (start) scl_o = 1'b0;
    endtask
    // MSB first, SDA released in the acknowledge slot
    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) clk_bit(d[i], s);
        clk_bit(1'b1, s);
        ack = ~s;
    endtask
    // acknowledge to continue, release to end
    task automatic recv_byte(input logic ack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(1'b1, s);
            d = {d[6:0], s};
        end
        clk_bit(~ack, s);
        rx_data_o = d;
        rx_valid_o = 1'b1;
        #1;
        rx_valid_o = 1'b0;
    endtask
endmodule

// >>> bench/tb_top.sv
// Self-checking bench for the I2C register slave with a master model.
// Assumes the package, design, checker and master model are compiled first.
`timescale 1ns/1ps
module tb_top;
    import i2c_slave_pkg::*;
    logic clk_i = 1'b0;
    logic link_clk = 1'b0;
    logic srst_i = 1'b1;
    logic addr_sel = 1'b0;
    logic [7:0] rd_addr = 8'h00;
    logic [7:0] rd_data, rx_data;
    logic scl, sda_rel, sda_o, sda_oe, wr_valid, rx_valid;
    reg_wr_t reg_wr;
    logic [7:0] shadow [256];
    logic [7:0] exp_rd [$];
    reg_wr_t exp_wr [$];
    logic [6:0] tbl [5] = '{7'h40, 7'h48, 7'h49, 7'h00, 7'h41};
    logic [7:0] chip_addr [5] = '{8'hfe, 8'hff, 8'h00, 8'h37, 8'h38};
    int miscompares = 0;
    int comparisons = 0;
    int seed = 92399;
    // Open-drain wire: pulled up unless either party pulls it low.
    wire logic sda = sda_oe ? (sda_rel & sda_o) : sda_rel;
    always #25 clk_i = ~clk_i;
    // Link clock is offset so its edges drift against the system clock.
    initial begin
        #3.7;
        forever #6 link_clk = ~link_clk;
    end
    i2c_register_slave #(.REG_COUNT(256)) DUT (.clk_i(clk_i), .srst_i(srst_i), .link_clk_i(link_clk),
        .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe), .addr_sel_i(addr_sel),
        .reg_wr_valid_o(wr_valid), .reg_wr_o(reg_wr), .sys_rd_addr_i(rd_addr), .sys_rd_data_o(rd_data));
    i2c_master_model u_m (.sda_i(sda), .scl_o(scl), .sda_rel_o(sda_rel), .rx_valid_o(rx_valid),
        .rx_data_o(rx_data));
    // Compares with case inequality so an unknown never passes.
    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t ns: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask
    task automatic conclude();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // Sends one byte and compares the acknowledge returned.
    task automatic put(input logic [7:0] b, input logic exp_ack);
        logic ack;
        u_m.send_byte(b, ack);
        check({15'h0000, ack}, {15'h0000, exp_ack}, "acknowledge");
    endtask
    // Addresses for writing, sets pointer p, then writes n random bytes.
    task automatic wr_burst(input logic [7:0] p, input int n);
        logic [7:0] d;
        put(8'h90, 1'b1);
        put(p, 1'b1);
        for (int k = 0; k < n; k++) begin
            d = 8'($random(seed));
            exp_wr.push_back({p, d});
            shadow[p] = d;
            put(d, 1'b1);
            p++;
        end
    endtask
    // Reads n bytes from pointer p, acknowledging all but the last.
    task automatic rd_burst(input logic [7:0] p, input int n);
        logic [7:0] d;
        put(8'h91, 1'b1);
        for (int k = 0; k < n; k++) begin
            exp_rd.push_back(shadow[p + 8'(k)]);
            u_m.recv_byte(k < n - 1, d);
        end
        // After the not-acknowledge the slave must not start another byte.
        #100;
        check({15'h0000, sda_oe}, 16'h0000, "release after not-acknowledge");
    endtask
    // Each write strobe or received byte is matched to the oldest note.
    always @(posedge clk_i) begin
        if (wr_valid === 1'b1) check(reg_wr, exp_wr.size() > 0 ? exp_wr.pop_front() : 16'hxxxx, "write");
    end
    always @(posedge rx_valid) begin
        check({8'h00, rx_data}, {8'h00, (exp_rd.size() > 0 ? exp_rd.pop_front() : 8'hxx)}, "read");
    end
    initial begin
        foreach (shadow[k])
            shadow[k] = 8'h00;
        repeat (16) @(posedge clk_i);
        srst_i <= 1'b0;
        rd_addr <= 8'($random(seed));
        repeat (8) @(posedge clk_i);
        #1;
        check({8'h00, rd_data}, 16'h0000, "reset value");
        check({15'h0000, sda_oe}, 16'h0000, "idle release");
        check({15'h0000, sda_o}, 16'h0000, "open-drain value");
        check(reg_wr, 16'h0000, "write record reset");
        for (int s = 0; s < 2; s++) begin
            @(posedge clk_i);
            addr_sel <= s[0];
            repeat (4) @(posedge clk_i);
            foreach (tbl[k]) begin
                u_m.cond(1'b1);
                put({tbl[k], 1'b0}, tbl[k] == (s ? 7'h48 : 7'h40));
                put(8'h00, tbl[k] == (s ? 7'h48 : 7'h40));
                u_m.cond(1'b0);
            end
        end
        // pointer wrap and repeated starts at the fast rate
        u_m.half_ns = 250;
        u_m.cond(1'b1);
        wr_burst(8'hfe, 3);
        u_m.cond(1'b1);
        wr_burst(8'hfe, 0);
        u_m.cond(1'b1);
        rd_burst(8'hfe, 3);
        u_m.cond(1'b0);
        // pointer kept across stop at the slow rate
        u_m.half_ns = 1000;
        u_m.cond(1'b1);
        wr_burst(8'h37, 2);
        u_m.cond(1'b0);
        u_m.cond(1'b1);
        wr_burst(8'h38, 0);
        u_m.cond(1'b0);
        u_m.cond(1'b1);
        rd_burst(8'h38, 2);
        u_m.cond(1'b0);
        // chip-side read port returns what the master wrote
        foreach (chip_addr[k]) begin
            @(posedge clk_i);
            rd_addr <= chip_addr[k];
            repeat (2) @(posedge clk_i);
            #1;
            check({8'h00, rd_data}, {8'h00, shadow[chip_addr[k]]}, "chip read");
        end
        repeat (10) @(posedge clk_i);
        check(16'(exp_wr.size() + exp_rd.size()), 16'h0000, "results outstanding");
        conclude();
    end
    // The run needs about half a millisecond; cut a hang at two.
    initial begin
        #2000000;
        miscompares++;
        conclude();
    end
endmodule
